/* File: verilog/psrc_top.sv */
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "psrc_defs.svh"

module psrc_top (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PSRC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Capability masks from the device configuration
	input wire logic [31:0] capability_mask_a,
	input wire logic [31:0] capability_mask_b,
	// Peripheral resets, active high
	output logic conv_0_reset,
	output logic sleep_power_module_reset,
	output logic watchdog_reset_bit,
	output logic analog_cmp_1_reset,
	output logic analog_cmp_0_reset,
	output logic [3:0] gp_counter_reset,
	output logic two_wire_1_reset,
	output logic two_wire_0_reset,
	output logic sync_serial_1_reset,
	output logic sync_serial_0_reset,
	output logic async_serial_1_reset,
	output logic async_serial_0_reset
);
	import psrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_sync_r;
	logic [1:0] rst_sync_nxt;
	logic rst_loc_n;

	// Shift ones in behind the released reset
	always_comb begin
		rst_sync_nxt = {rst_sync_r[0], 1'b1};
	end

	// Two stages so release never lands near a clock edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= rst_sync_nxt;
		end
	end
	assign rst_loc_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	psrc_sel_t sel;
	logic wr_en;

	// Full decode: an alias would let a stray write reset a peripheral
	// Unmapped addresses answer with an error and no side effect
	always_comb begin
		if (paddr == `PSRC_OFS_CTRL_A) begin
			sel = PSRC_SEL_A;
		end else if (paddr == `PSRC_OFS_CTRL_B) begin
			sel = PSRC_SEL_B;
		end else begin
			sel = PSRC_SEL_NONE;
		end
	end

	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	// Fault only in the access phase; decode glitches in idle cycles stay hidden
	assign pslverr = psel & penable & (sel == PSRC_SEL_NONE);
	assign wr_en = psel & penable & pwrite;

	// Bus phases as the checks below and further down see them
	sequence wr_a_s;
		psel && penable && pwrite && paddr == `PSRC_OFS_CTRL_A;
	endsequence
	sequence wr_b_s;
		psel && penable && pwrite && paddr == `PSRC_OFS_CTRL_B;
	endsequence
	sequence setup_rd_a_s;
		psel && !penable && !pwrite && paddr == `PSRC_OFS_CTRL_A;
	endsequence
	sequence setup_rd_b_s;
		psel && !penable && !pwrite && paddr == `PSRC_OFS_CTRL_B;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence

	// Every access phase is answered at once, and only unmapped ones fault
	no_wait_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		access_s |-> pready)
		else $error("access phase not answered at once");
	bad_addr_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		access_s |-> pslverr == (paddr != `PSRC_OFS_CTRL_A && paddr != `PSRC_OFS_CTRL_B))
		else $error("bus error flag does not match the address");

	////////////////////////////////////////////////////////////////////////
	// Control registers
	logic [31:0] ctrl_a_r;
	logic [31:0] ctrl_a_nxt;
	logic [31:0] ctrl_b_r;
	logic [31:0] ctrl_b_nxt;
	logic [31:0] wmask_a;
	logic [31:0] wmask_b;

	// Capability masks are static configuration on this clock, so no synchroniser
	// Absent peripherals and reserved bits are never writable
	assign wmask_a = capability_mask_a & `PSRC_IMPL_A;
	assign wmask_b = capability_mask_b & `PSRC_IMPL_B;

	// Masked merge keeps unwritable bits at their old value
	always_comb begin
		ctrl_a_nxt = ctrl_a_r;
		ctrl_b_nxt = ctrl_b_r;
		if (wr_en && sel == PSRC_SEL_A) begin
			ctrl_a_nxt = (ctrl_a_r & ~wmask_a) | (pwdata & wmask_a);
		end
		if (wr_en && sel == PSRC_SEL_B) begin
			ctrl_b_nxt = (ctrl_b_r & ~wmask_b) | (pwdata & wmask_b);
		end
	end

	// Both registers clear on the local reset, releasing every peripheral
	always_ff @(posedge clock or negedge rst_loc_n) begin
		if (!rst_loc_n) begin
			ctrl_a_r <= `PSRC_RST_CTRL_A;
			ctrl_b_r <= `PSRC_RST_CTRL_B;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
		end
	end

	// Reserved bits, outside the implemented set, can never read back as one
	resv_a_zero_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		(ctrl_a_r & ~`PSRC_IMPL_A) == 32'h0000_0000)
		else $error("reserved bit of register a is set");
	resv_b_zero_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		(ctrl_b_r & ~`PSRC_IMPL_B) == 32'h0000_0000)
		else $error("reserved bit of register b is set");
	// A fault answer must leave both registers alone
	bad_wr_keep_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		psel && penable && pwrite && sel == PSRC_SEL_NONE
		|=> ctrl_a_r == $past(ctrl_a_r) && ctrl_b_r == $past(ctrl_b_r))
		else $error("unmapped write changed a register");
	// Without a write of its own a register keeps every bit
	keep_reg_a_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		!(psel && penable && pwrite && paddr == `PSRC_OFS_CTRL_A) |=> ctrl_a_r == $past(ctrl_a_r))
		else $error("register a changed without a write");
	keep_reg_b_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		!(psel && penable && pwrite && paddr == `PSRC_OFS_CTRL_B) |=> ctrl_b_r == $past(ctrl_b_r))
		else $error("register b changed without a write");
	// Register b also comes out of reset cleared
	reset_b_zero_a: assert property (@(posedge clock)
		$rose(rst_loc_n) |-> ctrl_b_r == 32'h0000_0000)
		else $error("register b not zero after reset");

	////////////////////////////////////////////////////////////////////////
	// Read data
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// Registered read data; loaded in setup so it is valid in the access cycle
	// Costs a register, but keeps the decode path off prdata
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable && !pwrite) begin
			case (sel)
				PSRC_SEL_A: prdata_nxt = ctrl_a_r;
				PSRC_SEL_B: prdata_nxt = ctrl_b_r;
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_loc_n) begin
		if (!rst_loc_n) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end
	assign prdata = prdata_r;

	// Read data only moves on a read setup edge, so it stands through the access
	rd_hold_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved outside a read setup");
	// The word read from register a matches the reset pins it drives
	read_a_back_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		setup_rd_a_s ##1 access_s
		|-> {prdata[`PSRC_BIT_CONV0], prdata[`PSRC_BIT_SLEEP], prdata[`PSRC_BIT_WDOG]}
		== {conv_0_reset, sleep_power_module_reset, watchdog_reset_bit})
		else $error("read value of register a differs from reset outputs");
	// Unmapped reads return zero
	bad_rd_zero_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		psel && !penable && !pwrite && sel == PSRC_SEL_NONE ##1 access_s |-> prdata == 32'h0000_0000)
		else $error("unmapped read did not return zero");

	////////////////////////////////////////////////////////////////////////
	// Peripheral reset outputs, straight from the register bits
	// Flop-driven so the peripherals never see a decode glitch as a reset pulse
	// A bit at one holds its peripheral in reset; clearing it lets go on the next edge
	assign conv_0_reset = ctrl_a_r[`PSRC_BIT_CONV0];
	assign sleep_power_module_reset = ctrl_a_r[`PSRC_BIT_SLEEP];
	assign watchdog_reset_bit = ctrl_a_r[`PSRC_BIT_WDOG];
	assign analog_cmp_1_reset = ctrl_b_r[`PSRC_BIT_CMP1];
	assign analog_cmp_0_reset = ctrl_b_r[`PSRC_BIT_CMP0];

	// One reset line per general counter, each with its own write check
	for (genvar gi = 0; gi < `PSRC_GPC_COUNT; gi = gi + 1) begin : g_gpc
		// Checked bit by bit, since a capability mask may leave gaps
		assign gp_counter_reset[gi] = ctrl_b_r[`PSRC_BIT_GPC_LO + gi];
		gpc_bit_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
			wr_b_s and capability_mask_b[`PSRC_BIT_GPC_LO + gi]
			|=> gp_counter_reset[gi] == $past(pwdata[`PSRC_BIT_GPC_LO + gi]))
			else $error("counter reset did not follow its write bit");
	end

	assign two_wire_1_reset = ctrl_b_r[`PSRC_BIT_TWI1];
	assign two_wire_0_reset = ctrl_b_r[`PSRC_BIT_TWI0];
	assign sync_serial_1_reset = ctrl_b_r[`PSRC_BIT_SYN1];
	assign sync_serial_0_reset = ctrl_b_r[`PSRC_BIT_SYN0];
	assign async_serial_1_reset = ctrl_b_r[`PSRC_BIT_ASY1];
	assign async_serial_0_reset = ctrl_b_r[`PSRC_BIT_ASY0];

	////////////////////////////////////////////////////////////////////////
	// Assertions
	// Writes land on the next edge and masked bits keep their old value
	mask_a_write_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_a_s |=> ((ctrl_a_r ^ $past(ctrl_a_r)) & ~$past(wmask_a)) == 32'h0000_0000)
		else $error("masked bit of register a changed");
	mask_b_write_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_b_s |=> ((ctrl_b_r ^ $past(ctrl_b_r)) & ~$past(wmask_b)) == 32'h0000_0000)
		else $error("masked bit of register b changed");
	// Each write bit reaches its peripheral reset line on the following edge
	conv_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_a_s and capability_mask_a[16] |=> conv_0_reset == $past(pwdata[16]))
		else $error("converter reset did not follow write");
	sleep_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_a_s and capability_mask_a[6] |=> sleep_power_module_reset == $past(pwdata[6]))
		else $error("sleep module reset did not follow write");
	wdog_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_a_s and capability_mask_a[3] |=> watchdog_reset_bit == $past(pwdata[3]))
		else $error("watchdog reset did not follow write");
	cmp_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_b_s and capability_mask_b[25] && capability_mask_b[24]
		|=> {analog_cmp_1_reset, analog_cmp_0_reset} == $past(pwdata[25:24]))
		else $error("comparator resets did not follow write");
	gpc_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_b_s and capability_mask_b[19:16] == 4'hF |=> gp_counter_reset == $past(pwdata[19:16]))
		else $error("counter resets did not follow write");
	twi_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_b_s and capability_mask_b[14] && capability_mask_b[12]
		|=> {two_wire_1_reset, two_wire_0_reset} == {$past(pwdata[14]), $past(pwdata[12])})
		else $error("two-wire resets did not follow write");
	syn_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_b_s and capability_mask_b[5] && capability_mask_b[4]
		|=> {sync_serial_1_reset, sync_serial_0_reset} == $past(pwdata[5:4]))
		else $error("sync serial resets did not follow write");
	asy_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		wr_b_s and capability_mask_b[1] && capability_mask_b[0]
		|=> {async_serial_1_reset, async_serial_0_reset} == $past(pwdata[1:0]))
		else $error("async serial resets did not follow write");

	// Reset, hold and read-back behaviour of the reset lines
	reset_zero_a: assert property (@(posedge clock)
		$rose(rst_loc_n) |-> ctrl_a_r == 32'h0000_0000)
		else $error("register a not zero after reset");
	reset_outs_a: assert property (@(posedge clock)
		!rst_loc_n |-> {conv_0_reset, sleep_power_module_reset, watchdog_reset_bit} == 3'h0)
		else $error("register a reset lines active during reset");
	hold_reset_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		!(psel && penable && pwrite && paddr == `PSRC_OFS_CTRL_A) |=> watchdog_reset_bit == $past(watchdog_reset_bit))
		else $error("watchdog reset changed without a write");
	read_back_a: assert property (@(posedge clock) disable iff (!rst_loc_n)
		setup_rd_b_s ##1 access_s
		|-> prdata[25:24] == {analog_cmp_1_reset, analog_cmp_0_reset})
		else $error("read value differs from reset outputs");
endmodule
`default_nettype wire

/* File: verilog/psrc_defs.svh */
`ifndef PSRC_DEFS_SVH
`define PSRC_DEFS_SVH
// Register byte offsets
`define PSRC_OFS_CTRL_A 12'h040
`define PSRC_OFS_CTRL_B 12'h044
`define PSRC_ADDR_W 12
// Reset values
`define PSRC_RST_CTRL_A 32'h0000_0000
`define PSRC_RST_CTRL_B 32'h0000_0000
// Implemented bits of each register
`define PSRC_IMPL_A 32'h0001_0048
`define PSRC_IMPL_B 32'h030F_5033
// Field positions, register a
`define PSRC_BIT_CONV0 16
`define PSRC_BIT_SLEEP 6
`define PSRC_BIT_WDOG 3
// Field positions, register b
`define PSRC_BIT_CMP1 25
`define PSRC_BIT_CMP0 24
`define PSRC_BIT_GPC_LO 16
`define PSRC_GPC_COUNT 4
`define PSRC_BIT_TWI1 14
`define PSRC_BIT_TWI0 12
`define PSRC_BIT_SYN1 5
`define PSRC_BIT_SYN0 4
`define PSRC_BIT_ASY1 1
`define PSRC_BIT_ASY0 0
`endif

/* File: verilog/psrc_pkg.sv */
package psrc_pkg;
	// Register selected by the current bus address
	typedef enum logic [1:0] {PSRC_SEL_NONE, PSRC_SEL_A, PSRC_SEL_B} psrc_sel_t;
endpackage

/* File: dv/test_psrc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "psrc_defs.svh"
module test_psrc_top;
	typedef struct {logic [31:0] data; logic err; logic [14:0] outs;} psrc_note_t;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
	logic conv, slp, wdg, c1, c0, t1, t0, s1, s0, u1, u0;
	logic [3:0] gpc;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, capa, capb, model_a, model_b;
	psrc_note_t q[$];
	psrc_note_t n;
	psrc_note_t got;
	int errors, total_checks, cycles;
	integer seed = 93;
	wire logic [14:0] outs = {conv, slp, wdg, c1, c0, gpc, t1, t0, s1, s0, u1, u0};
	psrc_top i_psrc_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capability_mask_a(capa), .capability_mask_b(capb), .conv_0_reset(conv), .sleep_power_module_reset(slp),
		.watchdog_reset_bit(wdg), .analog_cmp_1_reset(c1), .analog_cmp_0_reset(c0), .gp_counter_reset(gpc),
		.two_wire_1_reset(t1), .two_wire_0_reset(t0), .sync_serial_1_reset(s1), .sync_serial_0_reset(s0),
		.async_serial_1_reset(u1), .async_serial_0_reset(u0));
	////////////////////////////////////////////////////////////////////////////////
	// Clock, and a cycle ceiling so a stuck bus cannot hang the run
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Expected reset pins, in the same order as the outs bundle
	function automatic logic [14:0] pins(input logic [31:0] a, input logic [31:0] b);
		return {a[16], a[6], a[3], b[25], b[24], b[19:16], b[14], b[12], b[5], b[4], b[1], b[0]};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Bus master: request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Write, keeping the model: only implemented and capable bits move
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] s;
		s = d;
		if (a == `PSRC_OFS_CTRL_A) s = (d & `PSRC_IMPL_A) | (model_a & ~`PSRC_IMPL_A);
		if (a == `PSRC_OFS_CTRL_B) s = (d & `PSRC_IMPL_B) | (model_b & ~`PSRC_IMPL_B);
		if (a == `PSRC_OFS_CTRL_A) model_a = (model_a & ~(`PSRC_IMPL_A & capa)) | (s & `PSRC_IMPL_A & capa);
		if (a == `PSRC_OFS_CTRL_B) model_b = (model_b & ~(`PSRC_IMPL_B & capb)) | (s & `PSRC_IMPL_B & capb);
		apb(1'b1, a, s);
	endtask
	// Read: the expected answer is queued before the access edge
	task automatic rd(input logic [11:0] a);
		n.data = (a == `PSRC_OFS_CTRL_A) ? model_a : (a == `PSRC_OFS_CTRL_B) ? model_b : 32'h00000000;
		n.err = (a != `PSRC_OFS_CTRL_A) && (a != `PSRC_OFS_CTRL_B);
		n.outs = pins(model_a, model_b);
		q.push_back(n);
		apb(1'b0, a, 32'h00000000);
	endtask
	// Monitor: each completed read takes the oldest note
	always @(posedge clock) begin
		if (rst_n && psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
			if (q.size() == 0) chk("note queue", 32'h1, 32'h0);
			else begin
				got = q.pop_front();
				chk("prdata", got.data, prdata);
				chk("pslverr", {31'h0, got.err}, {31'h0, pslverr});
				chk("reset pins", {17'h0, got.outs}, {17'h0, outs});
			end
		end
	end
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		model_a = 32'h00000000;
		model_b = 32'h00000000;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		capa = 32'hFFFFFFFF;
		capb = 32'hFFFFFFFF;
		errors = 0;
		total_checks = 0;
		cycles = 0;
		do_reset();
		rd(`PSRC_OFS_CTRL_A);
		rd(12'h048);
		$display("test reset values done");
		for (int i = 0; i < 32; i++) begin
			wr(`PSRC_OFS_CTRL_A, 32'h1 << i);
			rd(`PSRC_OFS_CTRL_A);
			wr(`PSRC_OFS_CTRL_B, 32'h1 << i);
			rd(`PSRC_OFS_CTRL_B);
		end
		$display("test bit walk done");
		for (int i = 0; i < 20; i++) begin
			capa <= $random(seed);
			capb <= $random(seed);
			@(posedge clock);
			wr(`PSRC_OFS_CTRL_A, $random(seed));
			wr(`PSRC_OFS_CTRL_B, $random(seed));
			rd(`PSRC_OFS_CTRL_A);
			rd(`PSRC_OFS_CTRL_B);
		end
		$display("test capability masking done");
		capa <= 32'h00000000;
		capb <= 32'h00000000;
		@(posedge clock);
		wr(`PSRC_OFS_CTRL_A, ~model_a);
		wr(`PSRC_OFS_CTRL_B, ~model_b);
		wr(12'h048, 32'hFFFFFFFF);
		rd(`PSRC_OFS_CTRL_A);
		rd(`PSRC_OFS_CTRL_B);
		capa <= 32'hFFFFFFFF;
		capb <= 32'hFFFFFFFF;
		@(posedge clock);
		wr(`PSRC_OFS_CTRL_A, 32'hFFFFFFFF);
		wr(`PSRC_OFS_CTRL_B, 32'hFFFFFFFF);
		rd(`PSRC_OFS_CTRL_B);
		wr(`PSRC_OFS_CTRL_A, 32'h00000000);
		wr(`PSRC_OFS_CTRL_B, 32'h00000000);
		rd(`PSRC_OFS_CTRL_A);
		wr(`PSRC_OFS_CTRL_A, 32'hFFFFFFFF);
		@(posedge clock);
		do_reset();
		rd(`PSRC_OFS_CTRL_A);
		rd(`PSRC_OFS_CTRL_B);
		$display("test release and mid-run reset done");
		repeat (3) @(posedge clock);
		print_verdict();
	end
endmodule
`default_nettype wire
